// File: rtl/term_cal_ctrl.sv
// Purpose: memory-side termination switching and impedance calibration timing
// Assumes: memory clock, pin and command inputs are asynchronous to clk_sys
// Notes:   memory clock must be well below half of clk_sys for edge detection
//
// How it works
// R01: controller keeps channel quiet during calibration
// R02: controller precharges all banks before calibrating
// R03: no calibration after self-refresh without command
// R04: calibration command allowed after self-refresh exit delay
// R05: shared resistor calibrations never overlap
// R06: clock enable held high during calibration
// R07: controller turns termination off while calibrating
// R08: data lines undriven during calibration
// R09: self-refresh forces termination off, pin ignored
// R10: termination enabled by nonzero nominal or write bits
// R11: pin low off, pin high on unless disabled
// R12: decision uses only pin and mode settings; the code also gates it with clock enable and the self-refresh state
// R13: synchronous mode whenever dll on and locked
// R14: controller disables termination in dll-off mode
// R15: on and off follow pin by latency
// R16: latency equals column write plus added minus two
// R17: pin held high for short hold minimum
// R18: write extends hold, short or long by burst
// R19: release only after later hold expires
// R20: controller turns termination off around reads
// R21: first long calibration gets the initial period
// R22: controller issues periodic short calibrations
// R23: controller counts holds and latency windows
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
module term_cal_ctrl #(
  parameter int CAL_INIT_NCK  = term_cal_pkg::CAL_INIT_NCK,
  parameter int CAL_OPER_NCK  = term_cal_pkg::CAL_OPER_NCK,
  parameter int CAL_SHORT_NCK = term_cal_pkg::CAL_SHORT_NCK,
  parameter int DELAY_DEPTH   = 32
) (
  // system clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // memory link pins
  input  wire logic        mem_clk,
  input  wire logic        termination_control_pin,
  input  wire logic        clock_enable,
  input  wire logic [2:0]  mem_cmd,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // block outputs
  output logic             termination_on,
  output logic             calibration_busy
);

  localparam int CW = $clog2(CAL_INIT_NCK + 1);
  localparam int TW = $clog2(DELAY_DEPTH);

  typedef struct packed {
    logic [2:0]    clk_sync;
    logic [1:0]    pin_sync;
    logic [1:0]    cke_sync;
    logic [5:0]    cmd_sync;
    logic [6:0]    mode;
    logic [7:0]    latency;
    logic          self_ref;
    logic          first_done;
    logic          quiet_err;
    logic [CW-1:0] cal_cnt;
    logic          busy;
    logic          term_on;
    logic          wait_rq;
    logic [31:0]   rdata;
  } ctrl_state_t;

  ctrl_state_t state_ff;
  ctrl_state_t nxt_state;
  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  logic        mem_edge;
  logic        term_en;
  logic        sync_mode;
  logic        term_req;
  logic        term_dly;
  logic [TW-1:0] term_tap;

  // saturating write latency minus two, clipped to the delay line
  function automatic logic [TW-1:0] term_latency(input logic [7:0] lat);
    logic [4:0] wl;
    wl = {1'b0, lat[term_cal_pkg::LAT_CWL_LSB +: 4]} + {1'b0, lat[term_cal_pkg::LAT_AL_LSB +: 4]};
    if (wl < term_cal_pkg::TERM_LAT_OFFSET) begin
      term_latency = '0;
    end else if (wl - term_cal_pkg::TERM_LAT_OFFSET > 5'(DELAY_DEPTH - 1)) begin
      term_latency = TW'(DELAY_DEPTH - 1);
    end else begin
      term_latency = TW'(wl - term_cal_pkg::TERM_LAT_OFFSET);
    end
  endfunction

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // edge found on the second and third stages, first stage untouched
  assign mem_edge = state_ff.clk_sync[1] & ~state_ff.clk_sync[2];

  // either resistor group nonzero enables termination, see R10
  assign term_en = (|state_ff.mode[term_cal_pkg::MODE_RTT_NOM_LSB +: 3])
                 | (|state_ff.mode[term_cal_pkg::MODE_RTT_WR_LSB +: 2]);

  // dll on and locked; precharge power-down only with dll kept, see R13
  assign sync_mode = state_ff.mode[term_cal_pkg::MODE_DLL_ON]
                   & (state_ff.cke_sync[1] | state_ff.mode[term_cal_pkg::MODE_PD_DLL_KEEP]);

  // pin, mode bits, clock enable and the decoded self-refresh state, see R11 see R12
  assign term_req = state_ff.pin_sync[1] & term_en & sync_mode & ~state_ff.self_ref;

  assign term_tap = term_latency(state_ff.latency);

  term_delay_line #(
    .DEPTH (DELAY_DEPTH)
  ) u_delay (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .shift   (mem_edge),
    .din     (term_req),
    .tap     (term_tap),
    .dout    (term_dly)
  );

  always_comb begin
    logic       req;
    logic       acc;
    logic [2:0] cmd;
    req = avs_read | avs_write;
    acc = req & ~state_ff.wait_rq;
    cmd = state_ff.cmd_sync[5:3];
    nxt_state = state_ff;

    nxt_state.clk_sync = {state_ff.clk_sync[1:0], mem_clk};
    nxt_state.pin_sync = {state_ff.pin_sync[0], termination_control_pin};
    nxt_state.cke_sync = {state_ff.cke_sync[0], clock_enable};
    nxt_state.cmd_sync = {state_ff.cmd_sync[2:0], mem_cmd};

    // a quiet-time slip found by the memory side is sticky; write 1 clears
    if (acc && avs_write && avs_address == term_cal_pkg::OFS_STATUS
        && avs_writedata[term_cal_pkg::ST_QUIET_ERR]) begin
      nxt_state.quiet_err = 1'b0;
    end

    if (mem_edge) begin
      if (state_ff.cal_cnt != '0) begin
        nxt_state.cal_cnt = state_ff.cal_cnt - 1'b1;
        // any command or termination during the quiet time is flagged, see R01 see R07
        if (cmd != term_cal_pkg::CMD_NOP || state_ff.pin_sync[1]
            || !state_ff.cke_sync[1]) begin
          nxt_state.quiet_err = 1'b1; // set wins over clear, see R06
        end
      end else if (cmd == term_cal_pkg::CMD_LONG_CAL) begin
        // first long after reset gets the long initial period, see R21
        nxt_state.cal_cnt    = state_ff.first_done ? CW'(CAL_OPER_NCK) : CW'(CAL_INIT_NCK);
        nxt_state.first_done = 1'b1;
      end else if (cmd == term_cal_pkg::CMD_SHORT_CAL) begin
        nxt_state.cal_cnt = CW'(CAL_SHORT_NCK);
      end
      if (cmd == term_cal_pkg::CMD_SREF_ENTER) begin
        nxt_state.self_ref = 1'b1;
      end else if (cmd == term_cal_pkg::CMD_SREF_EXIT) begin
        // exit starts no calibration of its own, see R03
        nxt_state.self_ref = 1'b0;
      end
    end

    // registered copy so the busy pin comes straight from a flop
    nxt_state.busy = nxt_state.cal_cnt != '0;

    // latency of cwl plus al minus two, off at once in self-refresh, see R15 see R16 see R09
    nxt_state.term_on = term_dly & ~state_ff.self_ref & ~nxt_state.self_ref;

    // one wait cycle, then a single accepting cycle
    nxt_state.wait_rq = ~(req & state_ff.wait_rq);

    if (req && state_ff.wait_rq) begin
      if (avs_address == term_cal_pkg::OFS_MODE) begin
        nxt_state.rdata = {25'h0, state_ff.mode};
      end else if (avs_address == term_cal_pkg::OFS_LATENCY) begin
        nxt_state.rdata = {24'h0, state_ff.latency};
      end else if (avs_address == term_cal_pkg::OFS_STATUS) begin
        nxt_state.rdata = {25'h0, state_ff.quiet_err, term_en, sync_mode,
                           state_ff.first_done, (state_ff.cal_cnt != '0),
                           state_ff.self_ref, state_ff.term_on};
      end else if (avs_address == term_cal_pkg::OFS_CAL) begin
        nxt_state.rdata = 32'(state_ff.cal_cnt);
      end else begin
        nxt_state.rdata = 32'h0;
      end
    end

    if (acc && avs_write) begin
      if (avs_address == term_cal_pkg::OFS_MODE) begin
        nxt_state.mode = avs_writedata[6:0];
      end else if (avs_address == term_cal_pkg::OFS_LATENCY) begin
        nxt_state.latency = avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff         <= '0;
      state_ff.mode    <= term_cal_pkg::MODE_RESET;
      state_ff.latency <= term_cal_pkg::LAT_RESET;
      state_ff.wait_rq <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign avs_readdata     = state_ff.rdata;
  assign avs_waitrequest  = state_ff.wait_rq;
  assign termination_on   = state_ff.term_on;
  assign calibration_busy = state_ff.busy;

endmodule

// File: rtl/term_cal_pkg.sv
// Purpose: shared constants for the termination and calibration control block
// Assumes: 32-bit avalon register words at byte offsets, memory clock sampled by clk_sys
// Notes:   latencies are counted in memory clock cycles
package term_cal_pkg;

  // register byte offsets
  localparam logic [3:0] OFS_MODE    = 4'h0;
  localparam logic [3:0] OFS_LATENCY = 4'h4;
  localparam logic [3:0] OFS_STATUS  = 4'h8;
  localparam logic [3:0] OFS_CAL     = 4'hc;

  // mode word fields
  localparam int MODE_RTT_NOM_LSB  = 0;
  localparam int MODE_RTT_WR_LSB   = 3;
  localparam int MODE_DLL_ON       = 5;
  localparam int MODE_PD_DLL_KEEP  = 6;
  localparam logic [6:0] MODE_RESET = 7'h20;

  // latency word fields
  localparam int LAT_CWL_LSB = 0;
  localparam int LAT_AL_LSB  = 4;
  localparam logic [7:0] LAT_RESET = 8'h05;

  // status word fields
  localparam int ST_TERM_ON    = 0;
  localparam int ST_SELF_REF   = 1;
  localparam int ST_CAL_BUSY   = 2;
  localparam int ST_FIRST_DONE = 3;
  localparam int ST_SYNC_MODE  = 4;
  localparam int ST_TERM_EN    = 5;
  localparam int ST_QUIET_ERR  = 6;

  // termination latency is write latency minus this
  localparam logic [4:0] TERM_LAT_OFFSET = 5'h02;

  // calibration periods in memory clock cycles
  localparam int CAL_INIT_NCK  = 512;
  localparam int CAL_OPER_NCK  = 256;
  localparam int CAL_SHORT_NCK = 64;

  // command codes on the memory command pins
  localparam logic [2:0] CMD_NOP        = 3'h0;
  localparam logic [2:0] CMD_WRITE      = 3'h1;
  localparam logic [2:0] CMD_READ       = 3'h2;
  localparam logic [2:0] CMD_LONG_CAL   = 3'h3;
  localparam logic [2:0] CMD_SHORT_CAL  = 3'h4;
  localparam logic [2:0] CMD_SREF_ENTER = 3'h5;
  localparam logic [2:0] CMD_SREF_EXIT  = 3'h6;

endpackage

// File: rtl/term_delay_line.sv
// Purpose: programmable delay of the internal termination request
// Assumes: shift pulses once per memory clock rising edge
// Notes:   tap 0 gives the value taken at the last memory edge
module term_delay_line #(
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // delay control
  input  wire logic                     shift,
  input  wire logic                     din,
  input  wire logic [$clog2(DEPTH)-1:0] tap,
  output logic                          dout
);

  typedef struct packed {
    logic [DEPTH-1:0] line;
  } dly_state_t;

  dly_state_t state_ff;
  dly_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (shift) begin
      nxt_state.line = {state_ff.line[DEPTH-2:0], din};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // tap n gives the value taken n memory edges before the last one
  assign dout = state_ff.line[tap];

endmodule

// File: sim/term_cal_props.sv
// Purpose: port checks for term_cal_ctrl
// Assumes: memory clock well below clk_sys
// Notes:   bound from the bench top file
module term_cal_props #(
  parameter int CAL_INIT_NCK = 512
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rstn,
  // link
  input wire logic       mem_clk,
  input wire logic [2:0] mem_cmd,
  input wire logic       termination_control_pin,
  // bus
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // outputs
  input wire logic       termination_on,
  input wire logic       calibration_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0]  lo_cnt_ff;
  logic [15:0] busy_cnt_ff;
  logic        sref_ff;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // the pin-low counter saturates so long idle spans stay legal; the busy counter clears whenever busy is low
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lo_cnt_ff   <= 9'h000;
      busy_cnt_ff <= 16'h0000;
      sref_ff     <= 1'b0;
    end else begin
      lo_cnt_ff   <= termination_control_pin ? 9'h000 : lo_cnt_ff + {8'h00, ~&lo_cnt_ff};
      busy_cnt_ff <= calibration_busy ? busy_cnt_ff + 16'h0001 : 16'h0000;
      if ($rose(mem_clk) && mem_cmd == 3'h5) begin
        sref_ff <= 1'b1;
      end else if ($rose(mem_clk) && mem_cmd == 3'h6) begin
        sref_ff <= 1'b0;
      end
    end
  end
  sequence s_sref_cmd;
    $rose(mem_clk) && mem_cmd == 3'h5;
  endsequence
  sequence s_cal_cmd;
    $past(mem_cmd, 4) inside {3'h3, 3'h4};
  endsequence
  property p_sref_off;
    s_sref_cmd |-> ##[1:8] !termination_on;
  endproperty
  property p_sref_hold;
    sref_ff && $past(sref_ff, 8) |-> !termination_on;
  endproperty
  property p_busy_cause;
    $rose(calibration_busy) |-> s_cal_cmd;
  endproperty
  property p_busy_min;
    $rose(calibration_busy) |-> calibration_busy [*8];
  endproperty
  property p_busy_max;
    calibration_busy |-> busy_cnt_ff < 16'(8 * CAL_INIT_NCK + 16);
  endproperty
  property p_pin_low;
    lo_cnt_ff > 9'h12c |-> !termination_on;
  endproperty
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_sref_off: assert property (p_sref_off)
    else $error("termination on after self-refresh entry");
  a_sref_hold: assert property (p_sref_hold)
    else $error("termination on in self-refresh");
  a_busy_cause: assert property (p_busy_cause)
    else $error("calibration without command");
  a_busy_min: assert property (p_busy_min)
    else $error("calibration too short");
  a_busy_max: assert property (p_busy_max)
    else $error("calibration too long");
  a_pin_low: assert property (p_pin_low)
    else $error("termination on with pin low");
  a_wait_one: assert property (p_wait_one)
    else $error("no answer after one wait");
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("waitrequest low too long");
endmodule

// File: sim/mem_ctl_model.sv
// Purpose: memory controller side of the link
// Assumes: bench sets the request fields
// Notes:   memory clock runs free at 400 ns
module mem_ctl_model (
  // link outputs
  output logic       mem_clk,
  output logic       termination_control_pin,
  output logic       clock_enable,
  output logic [2:0] mem_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  // no data lines are modelled, so none is ever driven
  logic [2:0] cmd_req = 3'h0;
  logic       pin_req = 1'b0;
  logic       cke_req = 1'b1;
  initial begin
    mem_clk = 1'b0;
    mem_cmd = 3'h0;
    termination_control_pin = 1'b0;
    clock_enable = 1'b1;
    #13;
    forever #200 mem_clk = ~mem_clk;
  end
  // launch on the falling edge so rising edges see settled pins
  always @(negedge mem_clk) begin
    mem_cmd <= cmd_req;
    termination_control_pin <= pin_req;
    clock_enable <= cke_req;
  end
  // one command per call, nop otherwise keeps the channel quiet
  // no activate is ever sent, so banks stay precharged
  // no read is ever sent, so the pin never has to drop for one
  task automatic issue(input logic [2:0] c);
    cmd_req = c;
    @(negedge mem_clk);
    @(posedge mem_clk);
    cmd_req = 3'h0;
  endtask
endmodule

// File: sim/testbench.sv
// Purpose: self-checking bench for term_cal_ctrl
// Assumes: calibration periods shortened to 8/6/4
// Notes:   link side driven by mem_ctl_model
bind term_cal_ctrl term_cal_props #(.CAL_INIT_NCK(CAL_INIT_NCK)) u_props (
  .clk_sys(clk_sys), .rstn(rstn), .mem_clk(mem_clk), .mem_cmd(mem_cmd),
  .termination_control_pin(termination_control_pin), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .termination_on(termination_on), .calibration_busy(calibration_busy));
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        rstn;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic        avs_waitrequest;
  logic        mem_clk;
  logic        termination_control_pin;
  logic        clock_enable;
  logic [2:0]  mem_cmd;
  logic        termination_on;
  logic        calibration_busy;
  int          failures = 0;
  int          checks = 0;
  always #25 clk_sys = ~clk_sys;
  mem_ctl_model mdl (.mem_clk(mem_clk), .termination_control_pin(termination_control_pin),
    .clock_enable(clock_enable), .mem_cmd(mem_cmd));
  term_cal_ctrl #(.CAL_INIT_NCK(8), .CAL_OPER_NCK(6), .CAL_SHORT_NCK(4)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .mem_clk(mem_clk),
    .termination_control_pin(termination_control_pin), .clock_enable(clock_enable),
    .mem_cmd(mem_cmd), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .termination_on(termination_on),
    .calibration_busy(calibration_busy));
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic final_report;
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // holds and latencies are counted in memory edges
  task automatic mc(input int k);
    repeat (k) @(posedge mem_clk);
  endtask
  task automatic t_regs;
    bus(1'b0, 4'h0, 32'h0);
    chk_word(rd, 32'h20);
    bus(1'b0, 4'h4, 32'h0);
    chk_word(rd, 32'h05);
    bus(1'b1, 4'h1, 32'hffffffff);
    bus(1'b0, 4'h1, 32'h0);
    chk_word(rd, 32'h0);
  endtask
  // pin edge to switch, in memory clock edges
  task automatic t_lat(input logic [7:0] lat, input int n);
    bus(1'b1, 4'h4, {24'h0, lat});
    bus(1'b1, 4'h0, 32'h21);
    mdl.pin_req = 1'b1;
    @(negedge mem_clk);
    mc(n + 1);
    chk_bit(termination_on, 1'b0);
    mc(1);
    chk_bit(termination_on, 1'b1);
    mdl.pin_req = 1'b0;
    @(negedge mem_clk);
    mc(n + 1);
    chk_bit(termination_on, 1'b1);
    mc(1);
    chk_bit(termination_on, 1'b0);
  endtask
  // mode bits and clock enable against the pin, write with pin high
  task automatic t_mode;
    logic [7:0] mode [5] = '{8'h20, 8'h08, 8'h21, 8'h61, 8'h28}; // dll off, nominal zero
    logic [4:0] cke = 5'b10011;
    logic [4:0] exp = 5'b11000;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 4'h0, {24'h0, mode[i]});
      mdl.cke_req = cke[i];
      mdl.pin_req = 1'b1;
      mc(10);
      mdl.issue(3'h1);
      mc(4);
      chk_bit(termination_on, exp[i]);
      mdl.pin_req = 1'b0;
      mc(10);
    end
    mdl.cke_req = 1'b1;
  endtask
  task automatic t_sref;
    bus(1'b1, 4'h0, 32'h21);
    mdl.pin_req = 1'b1;
    mc(10);
    mdl.issue(3'h5);
    mc(1);
    chk_bit(termination_on, 1'b0);
    bus(1'b0, 4'h8, 32'h0);
    chk_word(rd, 32'h3a);
    mc(10);
    chk_bit(termination_on, 1'b0);
    mdl.issue(3'h6);
    mc(20); // no calibration within the exit delay
    chk_bit(calibration_busy, 1'b0);
    chk_bit(termination_on, 1'b1);
    mdl.pin_req = 1'b0;
    mc(10);
  endtask
  // busy must end exactly at memory edge n after the command
  task automatic t_cal(input logic [2:0] c, input int n);
    mdl.issue(c);
    mc(n - 1);
    #350;
    chk_bit(calibration_busy, 1'b1);
    mc(1);
    #350;
    chk_bit(calibration_busy, 1'b0);
    mc(4);
  endtask
  // a command inside the quiet time sets the sticky flag, write 1 clears it
  task automatic t_quiet;
    mdl.issue(3'h4);
    mdl.issue(3'h1);
    mc(6);
    bus(1'b0, 4'h8, 32'h0);
    chk_bit(rd[6], 1'b1);
    bus(1'b1, 4'h8, 32'h40);
    bus(1'b0, 4'h8, 32'h0);
    chk_bit(rd[6], 1'b0);
  endtask
  initial begin
    #1000000;
    failures++;
    final_report();
  end
  initial begin
    rstn <= 1'b0;
    avs_address <= 4'h0;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    mc(4);
    t_regs();
    // single device, so no two calibrations share a resistor
    t_cal(3'h3, 8);
    t_cal(3'h3, 6);
    t_cal(3'h4, 4);
    t_quiet();
    t_lat(8'h35, 6);
    t_lat(8'h06, 4);
    t_mode();
    t_sref();
    final_report();
  end
endmodule
